// file: hdl/lmb_pkg.sv
// Package of constants and types for the buffer-one message port
// Summary of operation
// R01: 96-byte buffer one behind one 8-bit read/write port, reset zero.
// R02: The same port loads transmit messages and unloads received messages.
// R03: The port serves whichever HDLC controller the selection register names.
// R04: Host reads transmit free flag, bit 7 of transmit byte count, before loading.
// R05: When buffer one is free, written bytes form the outgoing LAPD message.
// R06: Sent transmit data cannot be read back by the host.
// R07: On receive end-of-transfer interrupt, host reads the receive pointer flag.
// R08: Device sets receive pointer flag when buffer one holds a new message.
// R09: With pointer at buffer one, successive reads return the message in order.
// R10: Byte index advances after every port read or write; code advances only on accepted writes and flagged reads.
// R11: Byte index returns to zero at reset and at each new load or unload.
package lmb_pkg;

    // Buffer geometry
    localparam int          BUF_DEPTH   = 96;
    localparam int          IDX_W       = 7;
    localparam int          DATA_W      = 8;
    localparam int          SEL_W       = 2;
    localparam int          ADDR_W      = 12;
    localparam int          FIFO_DEPTH  = 8;

    // Port location within a channel's register page and its reset value
    localparam logic [11:0] PORT_OFFSET = 12'h700;
    localparam logic [7:0]  PORT_RESET  = 8'h00;
    localparam logic [6:0]  IDX_FIRST   = 7'h00;
    localparam logic [6:0]  IDX_LAST    = 7'h5f;

    // Transmit streaming states
    typedef enum logic [1:0] {
        LMB_TX_IDLE,
        LMB_TX_READ,
        LMB_TX_WAIT,
        LMB_TX_OUT
    } lmb_tx_state_t;

endpackage

// file: hdl/lmb_mem.sv
// Single-port message storage with registered read data
`timescale 1ns/1ps
module lmb_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 96,
    parameter int AW    = 7
) (
    // Clock
    input  wire logic             clk,
    // Access port
    input  wire logic             en,
    input  wire logic             we,
    input  wire logic [AW-1:0]    addr,
    input  wire logic [WIDTH-1:0] wdata,
    output logic      [WIDTH-1:0] rdata_ff
);

    logic [WIDTH-1:0] mem_ff [DEPTH];

    // Storage has no reset; only written bytes are ever read
    always_ff @(posedge clk) begin
        if (en && we) begin
            mem_ff[addr] <= wdata;
        end
    end

    // Read data registered, valid the cycle after the request
    always_ff @(posedge clk) begin
        if (en && !we) begin
            rdata_ff <= mem_ff[addr];
        end
    end

endmodule

// file: hdl/lmb_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module lmb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Filling side
    input  wire logic             in_valid,
    output logic                  in_ready_ff,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    logic [WIDTH-1:0] buf_ff [DEPTH];
    logic [AW-1:0]    wp_ff;
    logic [AW-1:0]    rp_ff;
    logic [AW:0]      cnt_ff;
    logic [AW:0]      nxt_cnt;
    logic             push;
    logic             pop;

    // Handshakes and occupancy
    assign out_valid = (cnt_ff != '0);
    assign out_data  = buf_ff[rp_ff];
    assign push      = in_valid && in_ready_ff;
    assign pop       = out_valid && out_ready;
    assign nxt_cnt   = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);

    // Pointers wrap at the depth, not at a power of two
    always_ff @(posedge clk) begin
        if (rst) begin
            wp_ff       <= '0;
            rp_ff       <= '0;
            cnt_ff      <= '0;
            in_ready_ff <= 1'b0;
        end else begin
            if (push) begin
                wp_ff <= (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
            end
            if (pop) begin
                rp_ff <= (rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
            end
            cnt_ff      <= nxt_cnt;
            in_ready_ff <= (nxt_cnt != (AW+1)'(DEPTH));
        end
    end

    // Data array
    always_ff @(posedge clk) begin
        if (push) begin
            buf_ff[wp_ff] <= in_data;
        end
    end

endmodule

// file: hdl/lmb_top.sv
// Host port to LAPD message buffer one, with transmit and receive paths
`timescale 1ns/1ps
module lmb_top (
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst,
    // Microprocessor bus pins (asynchronous to clk)
    input  wire logic                         bus_cs_n,
    input  wire logic                         bus_rd_n,
    input  wire logic                         bus_wr_n,
    input  wire logic [lmb_pkg::ADDR_W-1:0]   bus_addr,
    input  wire logic [lmb_pkg::DATA_W-1:0]   bus_data_in,
    output logic      [lmb_pkg::DATA_W-1:0]   bus_data_out_ff,
    output logic                              bus_data_oe_n_ff,
    // Controller selection
    input  wire logic [lmb_pkg::SEL_W-1:0]    ctrl_sel,
    output logic      [lmb_pkg::SEL_W-1:0]    hdlc_sel_ff,
    // Transmit side of the selected controller
    input  wire logic                         tx_buffer_free_flag,
    input  wire logic                         tx_go,
    input  wire logic [lmb_pkg::IDX_W-1:0]    tx_len,
    output logic                              tx_valid_ff,
    input  wire logic                         tx_ready,
    output logic      [lmb_pkg::DATA_W-1:0]   tx_data_ff,
    output logic                              tx_done_ff,
    // Receive side of the selected controller
    input  wire logic                         rx_valid,
    output logic                              rx_ready_ff,
    input  wire logic [lmb_pkg::DATA_W-1:0]   rx_data,
    input  wire logic                         rx_eot,
    input  wire logic                         rx_eot_buf_one,
    input  wire logic [lmb_pkg::IDX_W-1:0]    rx_len,
    output logic                              rx_buffer_pointer_flag_ff,
    output logic                              rx_end_of_transfer_irq_ff
);

    localparam int SYNC_W = 3 + lmb_pkg::ADDR_W + lmb_pkg::DATA_W;

    // Pin synchroniser stages; only the second stage is read by logic
    logic [SYNC_W-1:0]             sync1_ff;
    logic [SYNC_W-1:0]             sync2_ff;
    logic                          s_cs_n;
    logic                          s_rd_n;
    logic                          s_wr_n;
    logic [lmb_pkg::ADDR_W-1:0]    s_addr;
    logic [lmb_pkg::DATA_W-1:0]    s_data;
    logic                          rd_act;
    logic                          wr_act;
    logic                          rd_act_ff;
    logic                          wr_act_ff;
    logic                          host_rd;
    logic                          host_wr;
    logic                          host_wr_ok;
    logic                          rd_pend_ff;
    logic                          rd_tx_ff;
    // Buffer state
    logic [lmb_pkg::IDX_W-1:0]     host_idx_ff;
    logic [lmb_pkg::IDX_W-1:0]     rx_wi_ff;
    logic [lmb_pkg::IDX_W-1:0]     rx_len_ff;
    logic [lmb_pkg::IDX_W-1:0]     tx_i_ff;
    logic [lmb_pkg::IDX_W-1:0]     tx_len_ff;
    logic                          tx_free_ff;
    logic                          eot_pend_ff;
    logic                          eot_one_ff;
    logic                          rx_land;
    logic                          rx_last_rd;
    logic                          tx_start;
    logic                          idx_restart;
    lmb_pkg::lmb_tx_state_t        tx_st_ff;
    // FIFO drain side
    logic                          fifo_valid;
    logic                          fifo_ready;
    logic [lmb_pkg::DATA_W-1:0]    fifo_data;
    // Memory port
    logic                          mem_en;
    logic                          mem_we;
    logic [lmb_pkg::IDX_W-1:0]     mem_addr;
    logic [lmb_pkg::DATA_W-1:0]    mem_wdata;
    logic [lmb_pkg::DATA_W-1:0]    mem_rdata;
    logic                          tx_issue;

    // Two-stage synchroniser for every bus pin
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_ff <= {3'h7, {(SYNC_W-3){1'b0}}};
            sync2_ff <= {3'h7, {(SYNC_W-3){1'b0}}};
        end else begin
            sync1_ff <= {bus_cs_n, bus_rd_n, bus_wr_n, bus_addr, bus_data_in};
            sync2_ff <= sync1_ff;
        end
    end

    assign {s_cs_n, s_rd_n, s_wr_n, s_addr, s_data} = sync2_ff;

    // Decode; the channel nibble is decoded outside
    assign rd_act = !s_cs_n && !s_rd_n && (s_addr == lmb_pkg::PORT_OFFSET);
    assign wr_act = !s_cs_n && !s_wr_n && (s_addr == lmb_pkg::PORT_OFFSET);

    // Strobe edge memory: one access per strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_act_ff <= 1'b0;
            wr_act_ff <= 1'b0;
        end else begin
            rd_act_ff <= rd_act;
            wr_act_ff <= wr_act;
        end
    end

    assign host_rd = rd_act && !rd_act_ff;
    assign host_wr = wr_act && !wr_act_ff;

    // Loads accepted only while buffer one is free and empty of rx data
    assign host_wr_ok = host_wr && tx_free_ff && !rx_buffer_pointer_flag_ff;  // see R05

    // A message lands once the queue has drained into memory
    assign rx_land    = eot_pend_ff && !fifo_valid;
    assign rx_last_rd = host_rd && rx_buffer_pointer_flag_ff
                        && (host_idx_ff == rx_len_ff - 1'b1);
    assign tx_start   = tx_go && !tx_free_ff && (tx_st_ff == lmb_pkg::LMB_TX_IDLE);

    // Index restarts whenever a new load or unload begins
    assign idx_restart = (rx_land && eot_one_ff)
                         || (tx_buffer_free_flag && !tx_free_ff)
                         || tx_start;  // see R11

    // Controller selection steers which controller owns the port
    always_ff @(posedge clk) begin
        if (rst) begin
            hdlc_sel_ff <= '0;
        end else begin
            hdlc_sel_ff <= ctrl_sel;  // see R03
        end
    end

    // Free flag copy so that its rising edge can restart a load
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_free_ff <= 1'b0;
        end else begin
            tx_free_ff <= tx_buffer_free_flag;  // see R04
        end
    end

    // Host byte index with automatic advance and wrap after the last byte
    always_ff @(posedge clk) begin
        if (rst) begin
            host_idx_ff <= lmb_pkg::IDX_FIRST;  // see R11
        end else if (idx_restart) begin
            host_idx_ff <= lmb_pkg::IDX_FIRST;  // see R11
        end else if (host_wr_ok || (host_rd && rx_buffer_pointer_flag_ff)) begin
            if (host_idx_ff == lmb_pkg::IDX_LAST) begin
                host_idx_ff <= lmb_pkg::IDX_FIRST;
            end else begin
                host_idx_ff <= host_idx_ff + 1'b1;  // see R10
            end
        end
    end

    // End of transfer waits for the queue to drain
    always_ff @(posedge clk) begin
        if (rst) begin
            eot_pend_ff <= 1'b0;
            eot_one_ff  <= 1'b0;
            rx_len_ff   <= '0;
        end else if (rx_eot) begin
            eot_pend_ff <= 1'b1;
            eot_one_ff  <= rx_eot_buf_one;
            rx_len_ff   <= rx_len;
        end else if (rx_land) begin
            eot_pend_ff <= 1'b0;
        end
    end

    // Pointer flag: set on landing wins over clear by the final host read
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_buffer_pointer_flag_ff <= 1'b0;
        end else if (rx_land && eot_one_ff) begin
            rx_buffer_pointer_flag_ff <= 1'b1;  // see R08
        end else if (rx_last_rd) begin
            rx_buffer_pointer_flag_ff <= 1'b0;
        end
    end

    // One-cycle end-of-transfer pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_end_of_transfer_irq_ff <= 1'b0;
        end else begin
            rx_end_of_transfer_irq_ff <= rx_land && eot_one_ff;  // see R07
        end
    end

    // Receive write index into buffer one
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_wi_ff <= lmb_pkg::IDX_FIRST;
        end else if (rx_land) begin
            rx_wi_ff <= lmb_pkg::IDX_FIRST;
        end else if (fifo_valid && fifo_ready) begin
            rx_wi_ff <= (rx_wi_ff == lmb_pkg::IDX_LAST) ? lmb_pkg::IDX_FIRST : rx_wi_ff + 1'b1;
        end
    end

    // Host accesses take the memory first; the drain stalls and the FIFO fills
    assign fifo_ready = !host_rd && !host_wr_ok && !rx_buffer_pointer_flag_ff;
    assign tx_issue   = (tx_st_ff == lmb_pkg::LMB_TX_READ) && !host_rd && !host_wr_ok
                        && !(fifo_valid && fifo_ready);

    // Memory port arbitration: host, then receive drain, then transmit
    always_comb begin
        mem_en    = 1'b0;
        mem_we    = 1'b0;
        mem_addr  = host_idx_ff;
        mem_wdata = s_data;
        if (host_wr_ok) begin
            mem_en = 1'b1;
            mem_we = 1'b1;  // see R02
        end else if (host_rd && rx_buffer_pointer_flag_ff) begin
            mem_en = 1'b1;  // see R09
        end else if (fifo_valid && fifo_ready) begin
            mem_en    = 1'b1;
            mem_we    = 1'b1;
            mem_addr  = rx_wi_ff;
            mem_wdata = fifo_data;
        end else if (tx_issue) begin
            mem_en   = 1'b1;
            mem_addr = tx_i_ff;
        end
    end

    // Host read pending; a read while not unloading returns zero
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_pend_ff <= 1'b0;
            rd_tx_ff   <= 1'b0;
        end else begin
            rd_pend_ff <= host_rd;
            rd_tx_ff   <= host_rd && !rx_buffer_pointer_flag_ff;
        end
    end

    // Port read data; transmit bytes are never exposed back to the host
    always_ff @(posedge clk) begin
        if (rst) begin
            bus_data_out_ff <= lmb_pkg::PORT_RESET;  // see R01
        end else if (rd_pend_ff) begin
            bus_data_out_ff <= rd_tx_ff ? lmb_pkg::PORT_RESET : mem_rdata;  // see R06
        end
    end

    // Data pins driven only during a decoded read strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            bus_data_oe_n_ff <= 1'b1;
        end else begin
            bus_data_oe_n_ff <= !rd_act;
        end
    end

    // Transmit message length captured at start
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_len_ff <= '0;
        end else if (tx_start) begin
            tx_len_ff <= tx_len;
        end
    end

    // Transmit streaming: each byte held until taken
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_st_ff    <= lmb_pkg::LMB_TX_IDLE;
            tx_i_ff     <= lmb_pkg::IDX_FIRST;
            tx_valid_ff <= 1'b0;
            tx_data_ff  <= '0;
            tx_done_ff  <= 1'b0;
        end else begin
            tx_done_ff <= 1'b0;
            case (tx_st_ff)
                lmb_pkg::LMB_TX_IDLE: begin
                    if (tx_start) begin
                        tx_i_ff  <= lmb_pkg::IDX_FIRST;
                        tx_st_ff <= lmb_pkg::LMB_TX_READ;
                    end
                end
                lmb_pkg::LMB_TX_READ: begin
                    if (tx_issue) begin
                        tx_st_ff <= lmb_pkg::LMB_TX_WAIT;
                    end
                end
                lmb_pkg::LMB_TX_WAIT: begin
                    tx_data_ff  <= mem_rdata;  // see R05
                    tx_valid_ff <= 1'b1;
                    tx_st_ff    <= lmb_pkg::LMB_TX_OUT;
                end
                lmb_pkg::LMB_TX_OUT: begin
                    if (tx_ready) begin
                        tx_valid_ff <= 1'b0;
                        if (tx_i_ff + 1'b1 >= tx_len_ff || tx_i_ff == lmb_pkg::IDX_LAST) begin
                            tx_done_ff <= 1'b1;
                            tx_st_ff   <= lmb_pkg::LMB_TX_IDLE;
                        end else begin
                            tx_i_ff  <= tx_i_ff + 1'b1;
                            tx_st_ff <= lmb_pkg::LMB_TX_READ;
                        end
                    end
                end
                default: begin
                    tx_st_ff <= lmb_pkg::LMB_TX_IDLE;
                end
            endcase
        end
    end

    // Receive bytes queue here so the controller is not held off by host access
    lmb_fifo #(
        .WIDTH (lmb_pkg::DATA_W),
        .DEPTH (lmb_pkg::FIFO_DEPTH),
        .AW    (3)
    ) u_rx_fifo (
        .clk         (clk),
        .rst         (rst),
        .in_valid    (rx_valid),
        .in_ready_ff (rx_ready_ff),
        .in_data     (rx_data),
        .out_valid   (fifo_valid),
        .out_ready   (fifo_ready),
        .out_data    (fifo_data)
    );

    // 96-byte storage of buffer one
    lmb_mem #(
        .WIDTH (lmb_pkg::DATA_W),
        .DEPTH (lmb_pkg::BUF_DEPTH),
        .AW    (lmb_pkg::IDX_W)
    ) u_mem (
        .clk      (clk),
        .en       (mem_en),
        .we       (mem_we),
        .addr     (mem_addr),
        .wdata    (mem_wdata),
        .rdata_ff (mem_rdata)
    );

endmodule

// file: testbench/lmb_top_asserts.sv
// Concurrent checks on the ports of the buffer-one message port
`timescale 1ns/1ps
module lmb_top_asserts (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Bus pins
    input wire logic        bus_cs_n,
    input wire logic        bus_rd_n,
    input wire logic [11:0] bus_addr,
    input wire logic [7:0]  bus_data_out_ff,
    input wire logic        bus_data_oe_n_ff,
    // Selection
    input wire logic [1:0]  ctrl_sel,
    input wire logic [1:0]  hdlc_sel_ff,
    // Streams
    input wire logic        tx_valid_ff,
    input wire logic        tx_ready,
    input wire logic [7:0]  tx_data_ff,
    input wire logic        tx_done_ff,
    input wire logic        rx_eot,
    input wire logic        rx_eot_buf_one,
    input wire logic        rx_buffer_pointer_flag_ff,
    input wire logic        rx_end_of_transfer_irq_ff
);
    logic rd_dec;

    // Read strobe decoded at the pins
    assign rd_dec = !bus_cs_n && !bus_rd_n && bus_addr == 12'h700;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Steps of a read and of a landing message
    sequence rd_held;
        rd_dec [*3];
    endsequence
    sequence rx_land;
        rx_eot && rx_eot_buf_one;
    endsequence

    a_reset_state: assert property (disable iff (1'b0) rst |=> bus_data_out_ff == 8'h00 && bus_data_oe_n_ff)
        else $error("port not at reset value");
    a_sel_copy: assert property (!$past(rst) |-> hdlc_sel_ff == $past(ctrl_sel))
        else $error("controller selection not followed");
    a_oe_on_read: assert property (rd_held |=> !bus_data_oe_n_ff)
        else $error("data pins not driven on read");
    a_oe_needs_read: assert property (!bus_data_oe_n_ff |-> $past(rd_dec, 3))
        else $error("data pins driven without read");
    a_data_after_read: assert property (!$stable(bus_data_out_ff) |-> $past(rd_dec, 4))
        else $error("read data changed without read");
    a_tx_hold: assert property (tx_valid_ff && !tx_ready |=> tx_valid_ff && $stable(tx_data_ff))
        else $error("transmit byte dropped while stalled");
    a_done_pulse: assert property (tx_done_ff |=> !tx_done_ff)
        else $error("transmit done longer than one cycle");
    a_flag_on_land: assert property (rx_land |-> ##[1:40] rx_buffer_pointer_flag_ff)
        else $error("pointer flag not set after landing");
    a_buf0_no_flag: assert property (rx_eot && !rx_eot_buf_one && !rx_buffer_pointer_flag_ff
                                     |=> !rx_buffer_pointer_flag_ff [*4])
        else $error("pointer flag set for other buffer");
    a_irq_pulse: assert property (rx_end_of_transfer_irq_ff |-> rx_buffer_pointer_flag_ff ##1
                                  !rx_end_of_transfer_irq_ff)
        else $error("end of transfer pulse wrong");
endmodule

// file: testbench/lmb_hdlc_model.sv
// Behavioural model of the selected HDLC controller's byte streams
`timescale 1ns/1ps
module lmb_hdlc_model (
    // Clock
    input  wire logic       clk,
    // Transmit byte sink
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       slow,
    output logic            tx_ready,
    // Receive byte source
    input  wire logic       rx_ready,
    output logic            rx_valid,
    output logic [7:0]      rx_data
);
    logic [7:0] cap [0:95];
    int         cap_n;

    initial begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        cap_n    = 0;
    end

    // Ready toggles when slow, so the sender must hold each byte
    always @(negedge clk) begin
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end

    // Keep every byte taken, in order
    always @(posedge clk) begin
        if (tx_valid && tx_ready) begin
            cap[cap_n] <= tx_data;
            cap_n      <= cap_n + 1;
        end
    end

    // Offer one received byte and hold it until taken
    task automatic send(input logic [7:0] b);
        @(negedge clk);
        rx_valid = 1'b1;
        rx_data  = b;
        while (!rx_ready) @(negedge clk);
        @(negedge clk);
        rx_valid = 1'b0;
        rx_data  = ~b; // Released lines must not show a stale byte
    endtask
endmodule

// file: testbench/test_lapd_message_buffer_one_port.sv
// Self-checking bench for the buffer-one message port
`timescale 1ns/1ps
module test_lapd_message_buffer_one_port;
    logic        clk;
    logic        rst;
    logic        bus_cs_n;
    logic        bus_rd_n;
    logic        bus_wr_n;
    logic [11:0] bus_addr;
    logic [7:0]  bus_data_in;
    logic [7:0]  bus_data_out_ff;
    logic        bus_data_oe_n_ff;
    logic [1:0]  ctrl_sel;
    logic [1:0]  hdlc_sel_ff;
    logic        tx_buffer_free_flag;
    logic        tx_go;
    logic [6:0]  tx_len;
    logic        tx_valid_ff;
    logic        tx_ready;
    logic [7:0]  tx_data_ff;
    logic        tx_done_ff;
    logic        rx_valid;
    logic        rx_ready_ff;
    logic [7:0]  rx_data;
    logic        rx_eot;
    logic        rx_eot_buf_one;
    logic [6:0]  rx_len;
    logic        rx_flag;
    logic        rx_irq;
    logic        slow;
    logic [7:0]  q;
    int          fail_count;
    int          n_compared;
    int          irq_n;
    int          cyc;

    lmb_top dut (
        .clk(clk), .rst(rst), .bus_cs_n(bus_cs_n), .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n),
        .bus_addr(bus_addr), .bus_data_in(bus_data_in), .bus_data_out_ff(bus_data_out_ff),
        .bus_data_oe_n_ff(bus_data_oe_n_ff), .ctrl_sel(ctrl_sel), .hdlc_sel_ff(hdlc_sel_ff),
        .tx_buffer_free_flag(tx_buffer_free_flag), .tx_go(tx_go), .tx_len(tx_len),
        .tx_valid_ff(tx_valid_ff), .tx_ready(tx_ready), .tx_data_ff(tx_data_ff), .tx_done_ff(tx_done_ff),
        .rx_valid(rx_valid), .rx_ready_ff(rx_ready_ff), .rx_data(rx_data), .rx_eot(rx_eot),
        .rx_eot_buf_one(rx_eot_buf_one), .rx_len(rx_len), .rx_buffer_pointer_flag_ff(rx_flag),
        .rx_end_of_transfer_irq_ff(rx_irq)
    );

    lmb_hdlc_model m (
        .clk(clk), .tx_valid(tx_valid_ff), .tx_data(tx_data_ff), .slow(slow), .tx_ready(tx_ready),
        .rx_ready(rx_ready_ff), .rx_valid(rx_valid), .rx_data(rx_data)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Count interrupt pulses and cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (rx_irq === 1'b1) irq_n++;
        if (cyc == 5000) begin
            fail_count++;
            final_report();
        end
    end

    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One host access, held long for the pin synchroniser
    task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d, output logic [7:0] r);
        @(negedge clk);
        bus_addr    = a;
        bus_data_in = d;
        bus_cs_n    = 1'b0;
        repeat (3) @(negedge clk);
        bus_rd_n = wr;
        bus_wr_n = !wr;
        repeat (6) @(negedge clk);
        r = bus_data_out_ff;
        bus_rd_n    = 1'b1;
        bus_wr_n    = 1'b1;
        bus_cs_n    = 1'b1;
        bus_data_in = ~d;
        repeat (4) @(negedge clk);
    endtask

    task automatic eot(input logic one, input logic [6:0] n);
        @(negedge clk);
        rx_eot         = 1'b1;
        rx_eot_buf_one = one;
        rx_len         = n;
        @(negedge clk);
        rx_eot = 1'b0;
        repeat (10) @(negedge clk);
    endtask

    task automatic t_reset();
        check("read data", 8'h00, bus_data_out_ff);
        check("pin enable", 8'h01, {7'h00, bus_data_oe_n_ff});
        check("pointer flag", 8'h00, {7'h00, rx_flag});
    endtask

    task automatic t_select();
        for (int s = 0; s < 4; s++) begin
            ctrl_sel = s[1:0];
            @(negedge clk);
            check("selection", {6'h00, s[1:0]}, {6'h00, hdlc_sel_ff});
        end
    endtask

    task automatic t_tx();
        tx_buffer_free_flag = 1'b1;
        repeat (3) @(negedge clk);
        for (int i = 0; i < 5; i++) bus(1'b1, 12'h700, 8'h30 + i[7:0], q);
        tx_buffer_free_flag = 1'b0;
        repeat (2) @(negedge clk);
        slow   = 1'b1;
        tx_len = 7'h05;
        tx_go  = 1'b1;
        @(negedge clk);
        tx_go = 1'b0;
        while (tx_done_ff !== 1'b1) @(negedge clk);
        check("tx count", 8'h05, m.cap_n[7:0]);
        for (int i = 0; i < 5; i++) check("tx byte", 8'h30 + i[7:0], m.cap[i]);
        bus(1'b0, 12'h700, 8'h55, q);
        check("tx readback", 8'h00, q);
    endtask

    task automatic t_rx();
        eot(1'b0, 7'h01);
        check("other buffer", 8'h00, {7'h00, rx_flag});
        for (int i = 0; i < 4; i++) m.send(8'ha0 + i[7:0]);
        eot(1'b1, 7'h04);
        check("pointer flag", 8'h01, {7'h00, rx_flag});
        check("irq pulses", 8'h01, irq_n[7:0]);
        for (int i = 0; i < 8; i++) m.send(8'hc0 + i[7:0]);
        repeat (2) @(negedge clk);
        check("fifo full", 8'h00, {7'h00, rx_ready_ff});
        bus(1'b0, 12'h701, 8'h00, q);
        check("unmapped", 8'h00, q);
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 12'h700, 8'h00, q);
            check("rx byte a", 8'ha0 + i[7:0], q);
        end
        check("flag cleared", 8'h00, {7'h00, rx_flag});
        repeat (20) @(negedge clk);
        check("fifo drained", 8'h01, {7'h00, rx_ready_ff});
        eot(1'b1, 7'h08);
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, 12'h700, 8'h00, q);
            check("rx byte b", 8'hc0 + i[7:0], q);
        end
        check("irq pulses", 8'h02, irq_n[7:0]);
    endtask

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        {fail_count, n_compared, irq_n, cyc} = '0;
        rst = 1'b1;
        {bus_cs_n, bus_rd_n, bus_wr_n} = 3'h7;
        bus_addr            = 12'h000;
        bus_data_in         = 8'h00;
        ctrl_sel            = 2'h0;
        tx_buffer_free_flag = 1'b0;
        tx_go               = 1'b0;
        tx_len              = 7'h00;
        rx_eot              = 1'b0;
        rx_eot_buf_one      = 1'b0;
        rx_len              = 7'h00;
        slow                = 1'b0;
        repeat (6) @(negedge clk);
        t_reset();
        rst = 1'b0;
        repeat (2) @(negedge clk);
        t_select();
        t_tx();
        t_rx();
        final_report();
    end
endmodule

bind lmb_top lmb_top_asserts u_chk (
    .clk(clk), .rst(rst), .bus_cs_n(bus_cs_n), .bus_rd_n(bus_rd_n), .bus_addr(bus_addr),
    .bus_data_out_ff(bus_data_out_ff), .bus_data_oe_n_ff(bus_data_oe_n_ff), .ctrl_sel(ctrl_sel),
    .hdlc_sel_ff(hdlc_sel_ff), .tx_valid_ff(tx_valid_ff), .tx_ready(tx_ready), .tx_data_ff(tx_data_ff),
    .tx_done_ff(tx_done_ff), .rx_eot(rx_eot), .rx_eot_buf_one(rx_eot_buf_one),
    .rx_buffer_pointer_flag_ff(rx_buffer_pointer_flag_ff), .rx_end_of_transfer_irq_ff(rx_end_of_transfer_irq_ff)
);
